//--- hw/apsr_defines.svh
`ifndef APSR_DEFINES_SVH
`define APSR_DEFINES_SVH

// register indices; byte address is four times the index
`define APSR_IDX_SEG5      5'h0C
`define APSR_IDX_SEG6      5'h0D
`define APSR_IDX_SEG7      5'h0E
`define APSR_IDX_SEG8      5'h0F
`define APSR_IDX_CTRL      5'h1E
`define APSR_IDX_STATUS    5'h1F

`define APSR_AMP_W         7
`define APSR_AMP_SIGN      6
`define APSR_SEG_RESET     7'h00
`define APSR_NUM_SEGS      8
`define APSR_NUM_HELD      4
`define APSR_FIRST_HELD    3'h4
`define APSR_LAST_SEG      3'h7
`define APSR_SEG_CYCLES    4

`define APSR_CTRL_ENABLE   0
`define APSR_CTRL_SHADOW   1
`define APSR_CTRL_RESET    2'h1

`define APSR_STAT_BUSY     0
`define APSR_STAT_SEG_LO   1
`define APSR_STAT_SEG_HI   3
`define APSR_STAT_MODE     4
`define APSR_STAT_CNT_LO   8
`define APSR_STAT_CNT_HI   15

`endif

//--- hw/apsr_pkg.sv
package apsr_pkg;

    typedef enum logic {APSR_IDLE, APSR_RUN} apsr_seq_state_type;
    typedef logic [6:0] apsr_amp_type;
    typedef logic [2:0] apsr_seg_type;
    typedef enum logic [2:0] {
        APSR_SLOT_SEG5,
        APSR_SLOT_SEG6,
        APSR_SLOT_SEG7,
        APSR_SLOT_SEG8,
        APSR_SLOT_CTRL,
        APSR_SLOT_STATUS,
        APSR_SLOT_NONE
    } apsr_slot_type;

endpackage

//--- hw/apsr_segment_seq.sv
`timescale 1ns/1ns
`default_nettype none
`include "apsr_defines.svh"

module apsr_segment_seq #(
    parameter int SEG_CYCLES = `APSR_SEG_CYCLES
) (
    input  wire logic            clk,
    input  wire logic            rst,
    input  wire logic            start,
    output apsr_pkg::apsr_seg_type seg_idx,
    output logic                 active,
    output logic                 load,
    output logic                 done
);
    import apsr_pkg::*;

    localparam int DW = (SEG_CYCLES > 1) ? $clog2(SEG_CYCLES) : 1;
    localparam logic [DW-1:0] DIV_LAST = DW'(SEG_CYCLES - 1);

    apsr_seq_state_type state_q;
    apsr_seq_state_type state_d;
    logic [DW-1:0]      div_q;
    logic [DW-1:0]      div_d;
    apsr_seg_type       seg_q;
    apsr_seg_type       seg_d;
    logic               seg_tick;

    assign seg_tick = (state_q == APSR_RUN) && (div_q == DIV_LAST);
    assign done     = seg_tick && (seg_q == `APSR_LAST_SEG);
    // a new pulse may start in the cycle the last one ends
    assign load     = start && ((state_q == APSR_IDLE) || done);
    assign seg_idx  = seg_q;
    assign active   = (state_q == APSR_RUN);

    always_comb
    begin
        state_d = state_q;
        div_d   = div_q;
        seg_d   = seg_q;
        case (state_q)
            APSR_IDLE:
            begin
                div_d = '0;
                seg_d = '0;
                if (load)
                    state_d = APSR_RUN;
            end
            APSR_RUN:
            begin
                div_d = seg_tick ? '0 : DW'(div_q + 1'b1);
                if (load)
                    seg_d = '0;
                else if (done)
                    state_d = APSR_IDLE;
                else if (seg_tick)
                    seg_d = 3'(seg_q + 1'b1);
            end
            default:
            begin
                state_d = APSR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_q <= APSR_IDLE;
            div_q   <= '0;
            seg_q   <= '0;
        end
        else
        begin
            state_q <= state_d;
            div_q   <= div_d;
            seg_q   <= seg_d;
        end
    end

endmodule

`default_nettype wire

//--- hw/apsr_regs.sv
// Summary of operation
// - arbitrary mode shapes pulse from programmed amplitudes
// - eight segments make one pulse period
// - amplitude is 7-bit sign-magnitude, bit 6 sign
// - register 01101 drives segment six
// - register 01110 drives segment seven
// - register 01111 drives segment eight
// - register 01100 drives segment five
`timescale 1ns/1ns
`default_nettype none
`include "apsr_defines.svh"

module apsr_regs #(
    parameter int SEG_CYCLES = `APSR_SEG_CYCLES
) (
    input  wire logic                  MCLK,
    input  wire logic                  RST,
    input  wire logic                  PSEL,
    input  wire logic                  PENABLE,
    input  wire logic                  PWRITE,
    input  wire logic [6:0]            PADDR,
    input  wire logic [31:0]           PWDATA,
    input  wire logic [3:0]            PSTRB,
    output logic [31:0]                PRDATA,
    output logic                       PREADY,
    output logic                       PSLVERR,
    input  wire logic                  ARB_MODE,
    input  wire logic                  TX_PULSE,
    input  wire apsr_pkg::apsr_amp_type SEG1_AMPLITUDE,
    input  wire apsr_pkg::apsr_amp_type SEG2_AMPLITUDE,
    input  wire apsr_pkg::apsr_amp_type SEG3_AMPLITUDE,
    input  wire apsr_pkg::apsr_amp_type SEG4_AMPLITUDE,
    input  wire apsr_pkg::apsr_amp_type PRESET_AMPLITUDE,
    output apsr_pkg::apsr_amp_type     AMPLITUDE,
    output logic [7:0]                 AMPLITUDE_TC,
    output apsr_pkg::apsr_seg_type     SEG_INDEX,
    output logic                       SEG_ACTIVE,
    output logic                       PULSE_DONE
);
    import apsr_pkg::*;

    // map a word index onto a register slot; used by read and write
    function automatic apsr_slot_type slot_of(input logic [4:0] idx);
        apsr_slot_type s;
        s = APSR_SLOT_NONE;
        case (idx)
            `APSR_IDX_SEG5:   s = APSR_SLOT_SEG5;
            `APSR_IDX_SEG6:   s = APSR_SLOT_SEG6;
            `APSR_IDX_SEG7:   s = APSR_SLOT_SEG7;
            `APSR_IDX_SEG8:   s = APSR_SLOT_SEG8;
            `APSR_IDX_CTRL:   s = APSR_SLOT_CTRL;
            `APSR_IDX_STATUS: s = APSR_SLOT_STATUS;
            default:          s = APSR_SLOT_NONE;
        endcase
        return s;
    endfunction

    // sign-magnitude to two's complement; minus zero becomes zero
    function automatic logic [7:0] to_twos(input apsr_amp_type a);
        logic [7:0] mag;
        mag = {2'b00, a[`APSR_AMP_SIGN-1:0]};
        if (a[`APSR_AMP_SIGN])
            return 8'(8'h00 - mag);
        return mag;
    endfunction

    // bus decode
    apsr_slot_type slot;
    logic          setup;
    logic          access;
    logic          mapped;
    logic          wr_en;
    logic          lane0;

    assign slot   = slot_of(PADDR[6:2]);
    assign setup  = PSEL && !PENABLE;
    assign access = PSEL && PENABLE;
    assign mapped = (slot != APSR_SLOT_NONE);
    assign lane0  = PSTRB[0];
    assign wr_en  = access && PWRITE && mapped && lane0;

    // zero wait states: read data is captured during setup
    assign PREADY  = 1'b1;
    assign PSLVERR = access && !mapped;

    // segment amplitude bank, segments five to eight
    apsr_amp_type seg_q [`APSR_NUM_HELD];
    apsr_amp_type seg_d [`APSR_NUM_HELD];
    apsr_amp_type shd_q [`APSR_NUM_HELD];
    apsr_amp_type shd_d [`APSR_NUM_HELD];

    // sequencer hooks
    apsr_seg_type seq_idx;
    logic         seq_active;
    logic         seq_load;
    logic         seq_done;
    logic         seq_start;

    genvar g;
    generate
        for (g = 0; g < `APSR_NUM_HELD; g++)
        begin : g_bank
            always_comb
            begin
                seg_d[g] = seg_q[g];
                shd_d[g] = shd_q[g];
                if (wr_en && (slot == apsr_slot_type'(g)))
                    seg_d[g] = PWDATA[`APSR_AMP_W-1:0];
                // snapshot at pulse start so a write cannot tear a pulse
                if (seq_load)
                    shd_d[g] = seg_d[g];
            end

            always_ff @(posedge MCLK or posedge RST)
            begin
                if (RST)
                begin
                    seg_q[g] <= `APSR_SEG_RESET;
                    shd_q[g] <= `APSR_SEG_RESET;
                end
                else
                begin
                    seg_q[g] <= seg_d[g];
                    shd_q[g] <= shd_d[g];
                end
            end
        end
    endgenerate

    // control and pulse counter
    logic [1:0] ctrl_q;
    logic [1:0] ctrl_d;
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;

    always_comb
    begin
        ctrl_d = ctrl_q;
        cnt_d  = cnt_q;
        if (wr_en && (slot == APSR_SLOT_CTRL))
            ctrl_d = PWDATA[1:0];
        // wraps; software reads differences
        if (seq_done)
            cnt_d = 8'(cnt_q + 1'b1);
    end

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            ctrl_q <= `APSR_CTRL_RESET;
            cnt_q  <= 8'h00;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            cnt_q  <= cnt_d;
        end
    end

    // read path
    logic [31:0] rd_q;
    logic [31:0] rd_d;
    logic [31:0] status;

    always_comb
    begin
        status = 32'h0000_0000;
        status[`APSR_STAT_BUSY] = seq_active;
        status[`APSR_STAT_SEG_HI:`APSR_STAT_SEG_LO] = seq_idx;
        status[`APSR_STAT_MODE] = ARB_MODE;
        status[`APSR_STAT_CNT_HI:`APSR_STAT_CNT_LO] = cnt_q;
    end

    always_comb
    begin
        rd_d = rd_q;
        if (setup && !PWRITE)
        begin
            case (slot)
                APSR_SLOT_SEG5,
                APSR_SLOT_SEG6,
                APSR_SLOT_SEG7,
                APSR_SLOT_SEG8:   rd_d = {25'h0, seg_q[2'(slot)]};
                APSR_SLOT_CTRL:   rd_d = {30'h0, ctrl_q};
                APSR_SLOT_STATUS: rd_d = status;
                default:          rd_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
            rd_q <= 32'h0000_0000;
        else
            rd_q <= rd_d;
    end

    assign PRDATA = rd_q;

    // pulse timing
    assign seq_start = TX_PULSE && ctrl_q[`APSR_CTRL_ENABLE];

    apsr_segment_seq #(
        .SEG_CYCLES (SEG_CYCLES)
    ) u_seq (
        .clk     (MCLK),
        .rst     (RST),
        .start   (seq_start),
        .seg_idx (seq_idx),
        .active  (seq_active),
        .load    (seq_load),
        .done    (seq_done)
    );

    // amplitude selection
    apsr_amp_type held;
    apsr_amp_type amp_sel;
    logic [1:0]   held_idx;

    assign held_idx = seq_idx[1:0];

    always_comb
    begin
        held = ctrl_q[`APSR_CTRL_SHADOW] ? shd_q[held_idx] : seg_q[held_idx];
        amp_sel = `APSR_SEG_RESET;
        if (seq_active)
        begin
            if (!ARB_MODE)
                amp_sel = PRESET_AMPLITUDE;
            else
            begin
                case (seq_idx)
                    3'h0:    amp_sel = SEG1_AMPLITUDE;
                    3'h1:    amp_sel = SEG2_AMPLITUDE;
                    3'h2:    amp_sel = SEG3_AMPLITUDE;
                    3'h3:    amp_sel = SEG4_AMPLITUDE;
                    default: amp_sel = held;
                endcase
            end
        end
    end

    // output stage
    apsr_amp_type amp_q;
    apsr_amp_type amp_d;
    logic [7:0]   tc_q;
    logic [7:0]   tc_d;
    apsr_seg_type idx_q;
    apsr_seg_type idx_d;
    logic         act_q;
    logic         act_d;
    logic         done_q;
    logic         done_d;

    always_comb
    begin
        amp_d  = amp_sel;
        tc_d   = to_twos(amp_sel);
        idx_d  = seq_active ? seq_idx : 3'h0;
        act_d  = seq_active;
        done_d = seq_done;
    end

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            amp_q  <= `APSR_SEG_RESET;
            tc_q   <= 8'h00;
            idx_q  <= 3'h0;
            act_q  <= 1'b0;
            done_q <= 1'b0;
        end
        else
        begin
            amp_q  <= amp_d;
            tc_q   <= tc_d;
            idx_q  <= idx_d;
            act_q  <= act_d;
            done_q <= done_d;
        end
    end

    assign AMPLITUDE    = amp_q;
    assign AMPLITUDE_TC = tc_q;
    assign SEG_INDEX    = idx_q;
    assign SEG_ACTIVE   = act_q;
    assign PULSE_DONE   = done_q;

endmodule

`default_nettype wire

//--- test/apsr_regs_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module apsr_regs_asserts #(
    parameter int SEG_CYCLES = 4
) (
    input wire logic                   MCLK,
    input wire logic                   RST,
    input wire logic                   PSEL,
    input wire logic                   PENABLE,
    input wire logic                   PREADY,
    input wire logic                   PSLVERR,
    input wire logic                   ARB_MODE,
    input wire apsr_pkg::apsr_amp_type PRESET_AMPLITUDE,
    input wire apsr_pkg::apsr_amp_type AMPLITUDE,
    input wire logic [7:0]             AMPLITUDE_TC,
    input wire apsr_pkg::apsr_seg_type SEG_INDEX,
    input wire logic                   SEG_ACTIVE,
    input wire logic                   PULSE_DONE
);
    import apsr_pkg::*;
    apsr_seg_type idx_q;
    logic         act_q;
    logic [7:0]   run_q;
    logic         same;
    logic [7:0]   len;
    logic [7:0]   run_d;
    // cycles the current segment has been shown, this one included
    always_comb
    begin
        same = SEG_ACTIVE && act_q && SEG_INDEX == idx_q;
        len = same ? run_q + 8'h01 : 8'h01;
        run_d = SEG_ACTIVE ? len : 8'h00;
    end
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            idx_q <= 3'h0;
            act_q <= 1'b0;
            run_q <= 8'h00;
        end
        else
        begin
            idx_q <= SEG_INDEX;
            act_q <= SEG_ACTIVE;
            run_q <= run_d;
        end
    end
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (RST);
    sequence s_pulse_start;
        $rose(SEG_ACTIVE);
    endsequence
    sequence s_seg_change;
        SEG_ACTIVE && act_q && !same;
    endsequence
    a_ready_high: assert property (PREADY) else $error("wait state seen");
    a_err_access: assert property (PSLVERR |-> PSEL && PENABLE) else $error("error outside access");
    a_idle_zero: assert property (!SEG_ACTIVE |-> AMPLITUDE == 7'h00 && SEG_INDEX == 3'h0)
        else $error("idle output not zero");
    a_start_first: assert property (s_pulse_start |-> SEG_INDEX == 3'h0)
        else $error("pulse not started at segment one");
    a_seg_ascend: assert property (s_seg_change |-> SEG_INDEX == idx_q + 3'h1)
        else $error("segment order broken");
    a_seg_length: assert property (SEG_ACTIVE |-> len <= SEG_CYCLES)
        else $error("segment too long");
    a_seg_full: assert property (s_seg_change |-> run_q == SEG_CYCLES)
        else $error("segment too short");
    // done rises while the last segment still shows, in its final cycle
    a_done_last: assert property (PULSE_DONE |-> SEG_ACTIVE && SEG_INDEX == 3'h7 && len == SEG_CYCLES)
        else $error("done without full last segment");
    a_tc_value: assert property (AMPLITUDE_TC == (AMPLITUDE[6] ? 8'h00 - {2'h0, AMPLITUDE[5:0]}
        : {2'h0, AMPLITUDE[5:0]})) else $error("twos complement wrong");
    a_preset_mode: assert property (SEG_ACTIVE && !ARB_MODE |-> AMPLITUDE == PRESET_AMPLITUDE)
        else $error("preset shape not used");
endmodule
`default_nettype wire

//--- test/apsr_line_model.sv
`timescale 1ns/1ns
`default_nettype none
module apsr_line_model (
    input wire logic                   clk,
    input wire logic                   rst,
    input wire logic                   active,
    input wire apsr_pkg::apsr_seg_type idx,
    input wire apsr_pkg::apsr_amp_type amp,
    output logic [55:0]                wave,
    output logic                       glitch
);
    import apsr_pkg::*;
    apsr_amp_type last_q;
    apsr_seg_type idx_q;
    logic         act_q;
    // a driver level that moves inside a segment distorts the pulse
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wave <= 56'h0;
            glitch <= 1'b0;
            last_q <= 7'h00;
            idx_q <= 3'h0;
            act_q <= 1'b0;
        end
        else
        begin
            if (active)
                wave[idx*7 +: 7] <= amp;
            if (active && act_q && idx == idx_q && amp != last_q)
                glitch <= 1'b1;
            last_q <= amp;
            idx_q <= idx;
            act_q <= active;
        end
    end
endmodule
`default_nettype wire

//--- test/apsr_regs_test.sv
`timescale 1ns/1ns
`default_nettype none
`include "apsr_defines.svh"
module apsr_regs_test;
    import apsr_pkg::*;
    logic         MCLK = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, ARB_MODE = 0, TX_PULSE = 0;
    logic [6:0]   PADDR = 7'h00;
    logic [3:0]   PSTRB = 4'hF;
    logic [31:0]  PWDATA = 32'h0, PRDATA, rd, lf = 32'h17C470AF;
    logic         PREADY, PSLVERR, SEG_ACTIVE, PULSE_DONE, err, glitch;
    logic [7:0]   AMPLITUDE_TC;
    logic [55:0]  wave;
    apsr_amp_type a[1:8] = '{default: 7'h00};
    apsr_amp_type pre = 7'h00, AMPLITUDE;
    apsr_seg_type SEG_INDEX;
    int           num_errors = 0, total_checks = 0, n, r, k;
    always #50 MCLK = ~MCLK;
    apsr_regs #(.SEG_CYCLES(4)) u_apsr_regs (.MCLK(MCLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .ARB_MODE(ARB_MODE), .TX_PULSE(TX_PULSE), .SEG1_AMPLITUDE(a[1]),
        .SEG2_AMPLITUDE(a[2]), .SEG3_AMPLITUDE(a[3]), .SEG4_AMPLITUDE(a[4]), .PRESET_AMPLITUDE(pre),
        .AMPLITUDE(AMPLITUDE), .AMPLITUDE_TC(AMPLITUDE_TC), .SEG_INDEX(SEG_INDEX),
        .SEG_ACTIVE(SEG_ACTIVE), .PULSE_DONE(PULSE_DONE));
    apsr_line_model u_apsr_line_model (.clk(MCLK), .rst(RST), .active(SEG_ACTIVE), .idx(SEG_INDEX),
        .amp(AMPLITUDE), .wave(wave), .glitch(glitch));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [63:0] exp_wave(input logic m);
        exp_wave = 64'h0;
        for (int s = 0; s < 8; s++)
            exp_wave[s*7 +: 7] = m ? a[s+1] : pre;
    endfunction
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [4:0] i, input logic [31:0] d, input logic [3:0] st);
        @(posedge MCLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= {i, 2'h0};
        PWDATA <= d;
        PSTRB <= st;
        @(posedge MCLK);
        PENABLE <= 1'b1;
        @(posedge MCLK);
        while (PREADY !== 1'b1)
            @(posedge MCLK);
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task automatic fire;
        @(posedge MCLK);
        TX_PULSE <= 1'b1;
        @(posedge MCLK);
        TX_PULSE <= 1'b0;
        r = 0;
        while (PULSE_DONE !== 1'b1 && r < 200)
        begin
            @(posedge MCLK);
            r++;
        end
        chk(PULSE_DONE, 64'h1);
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (10) @(posedge MCLK);
        RST <= 1'b0;
        for (r = 0; r < 4; r++)
        begin
            apb(1'b0, 5'(`APSR_IDX_SEG5 + r), 32'h0, 4'hF);
            chk(rd, 64'h0);
        end
        // random data and strobes; a cleared low strobe must leave the register alone
        for (n = 0; n < 24; n++)
        begin
            lf = lfsr(lf);
            k = lf[25:24];
            apb(1'b1, 5'(`APSR_IDX_SEG5 + k), lf, lf[29:26]);
            if (lf[26])
                a[k+5] = lf[6:0];
            apb(1'b0, 5'(`APSR_IDX_SEG5 + k), 32'h0, 4'hF);
            chk(rd, {57'h0, a[k+5]});
        end
        apb(1'b1, 5'h10, 32'hFFFFFFFF, 4'hF);
        chk(err, 64'h1);
        apb(1'b0, 5'h10, 32'h0, 4'hF);
        chk({err, rd}, 64'h100000000);
        for (n = 0; n < 6; n++)
        begin
            lf = lfsr(lf);
            ARB_MODE <= n[0];
            pre <= lf[6:0];
            for (r = 1; r < 5; r++)
                a[r] <= lf[r*6 +: 7];
            apb(1'b1, 5'(`APSR_IDX_SEG5 + n % 4), {25'h0, lf[14:8]}, 4'hF);
            a[5 + n % 4] = lf[14:8];
            fire;
            chk(wave, exp_wave(n[0]));
        end
        // six pulses counted, mode bit shows arbitrary, sequencer idle
        apb(1'b0, `APSR_IDX_STATUS, 32'h0, 4'hF);
        chk(rd, 64'h0000_0610);
        // held request runs pulses back to back, index wraps from eight to one
        TX_PULSE <= 1'b1;
        repeat (40) @(posedge MCLK);
        TX_PULSE <= 1'b0;
        repeat (80) @(posedge MCLK);
        chk(glitch, 64'h0);
        // snapshot on: writes during back-to-back pulses must not move a segment's level
        apb(1'b1, `APSR_IDX_CTRL, 32'h3, 4'hF);
        apb(1'b0, `APSR_IDX_CTRL, 32'h0, 4'hF);
        chk(rd, 64'h3);
        TX_PULSE <= 1'b1;
        for (n = 0; n < 12; n++)
        begin
            lf = lfsr(lf);
            k = lf[25:24];
            apb(1'b1, 5'(`APSR_IDX_SEG5 + k), lf, 4'hF);
            a[k+5] = lf[6:0];
        end
        TX_PULSE <= 1'b0;
        repeat (80) @(posedge MCLK);
        chk(glitch, 64'h0);
        fire;
        chk(wave, exp_wave(1'b1));
        report_and_stop;
    end
    initial
    begin
        repeat (5000) @(posedge MCLK);
        num_errors++;
        report_and_stop;
    end
endmodule
bind apsr_regs apsr_regs_asserts #(.SEG_CYCLES(SEG_CYCLES)) u_apsr_regs_asserts (.MCLK(MCLK), .RST(RST),
    .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY), .PSLVERR(PSLVERR), .ARB_MODE(ARB_MODE),
    .PRESET_AMPLITUDE(PRESET_AMPLITUDE), .AMPLITUDE(AMPLITUDE), .AMPLITUDE_TC(AMPLITUDE_TC),
    .SEG_INDEX(SEG_INDEX), .SEG_ACTIVE(SEG_ACTIVE), .PULSE_DONE(PULSE_DONE));
`default_nettype wire
